// >>> hw/upcc_pkg.sv
// shared constants of the phy common-block control register.
// assumes a 32-bit classic wishbone bus with byte addresses.
package upcc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          DATA_W      = 32;
  localparam logic [11:0] CTL_OFFSET  = 12'h000;
  localparam logic [31:0] CTL_RESET   = 32'h0001_0000;
  localparam logic [31:0] CTL_WR_MASK = 32'h818B_CA01;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_CLK_OFF   = 31;
  localparam int B_TEST_SEL  = 24;
  localparam int B_XTAL_GAIN = 23;
  localparam int B_REF_FREQ  = 19;
  localparam int B_CORE_RDY  = 18;
  localparam int B_LPM       = 17;
  localparam int B_PLL_EN    = 16;
  localparam int B_SUSP_N    = 15;
  localparam int B_XSUSP_N   = 14;
  localparam int B_PLL_OK    = 12;
  localparam int B_SS_EN     = 11;
  localparam int B_SS_OK     = 10;
  localparam int B_TIM_OFF   = 9;
  localparam int B_GATE_BYP  = 0;

  // ****************************************
  // status synchroniser lanes
  // ****************************************
  localparam int STAT_W      = 4;
  localparam int S_CORE      = 0;
  localparam int S_POR3V     = 1;
  localparam int S_PLL_OK    = 2;
  localparam int S_SS_OK     = 3;

endpackage : upcc_pkg

// >>> hw/upcc_reload_if.sv
// carries the lpm default reload from the image tracker to the register.
// assumes both ends run on the same clock.
interface upcc_reload_if;
  logic load;
  logic value;
  modport src (output load, output value);
  modport dst (input  load, input  value);
endinterface : upcc_reload_if

// >>> hw/upcc_sync.sv
// per-bit three-stage synchroniser for asynchronous status levels.
// assumes inputs are slow levels; a change counts once stages 2 and 3 agree.
module upcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  initial begin
    if (W < 1) $error("upcc_sync: W must be at least 1");
  end

  for (genvar g = 0; g < W; g++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
      end else begin
        s1 <= async_i[g];
        s2 <= s1;
        s3 <= s2;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync_o[g] <= 1'b0;
      end else if (s2 == s3) begin
        sync_o[g] <= s3;
      end
    end
  end
endmodule : upcc_sync

// >>> hw/upcc_reload.sv
// tracks the last loaded config image and issues lpm default reloads.
// assumes image, usb reset and lite reset strobes come from clk_i logic.
module upcc_reload (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   image_load_i,
  input  wire logic   eeprom_present_i,
  input  wire logic   otp_present_i,
  input  wire logic   hs_mode_i,
  input  wire logic   eeprom_lpm_hs_i,
  input  wire logic   eeprom_lpm_fs_i,
  input  wire logic   otp_lpm_i,
  input  wire logic   usb_reset_i,
  input  wire logic   lite_reset_i,
  upcc_reload_if.src  rl
);
  logic image_bit;
  logic next_image_bit;

  // eeprom wins over otp; speed picks the eeprom variant; neither gives 0
  always_comb begin
    next_image_bit = 1'b0;
    if (eeprom_present_i) begin
      next_image_bit = hs_mode_i ? eeprom_lpm_hs_i : eeprom_lpm_fs_i;
    end else if (otp_present_i) begin
      next_image_bit = otp_lpm_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      image_bit <= 1'b0;
    end else if (image_load_i) begin
      image_bit <= next_image_bit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rl.load  <= 1'b0;
      rl.value <= 1'b0;
    end else begin
      rl.load  <= image_load_i | usb_reset_i | lite_reset_i;
      rl.value <= image_load_i ? next_image_bit : image_bit;
    end
  end
endmodule : upcc_reload

// >>> hw/upcc_top.sv
// common-block clock and power control register of a usb phy.
// assumes a classic wishbone master on clk_i and async analog status.
module upcc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        stb_i,
  input  wire logic        cyc_i,
  output logic             ack_o,
  input  wire logic        core_supply_ok_i,
  input  wire logic        por_3v_ok_i,
  input  wire logic        pll_usable_i,
  input  wire logic        ss_tx_pll_usable_i,
  input  wire logic        func_pll_enable_i,
  input  wire logic        func_shared_suspend_n_i,
  input  wire logic        func_crystal_suspend_n_i,
  input  wire logic        func_pll_fast_start_i,
  input  wire logic        local_suspend_n_i,
  input  wire logic        image_load_i,
  input  wire logic        eeprom_present_i,
  input  wire logic        otp_present_i,
  input  wire logic        hs_mode_i,
  input  wire logic        eeprom_lpm_hs_i,
  input  wire logic        eeprom_lpm_fs_i,
  input  wire logic        otp_lpm_i,
  input  wire logic        usb_reset_i,
  input  wire logic        lite_reset_i,
  output logic             common_reg_clk_en_o,
  output logic             shared_block_test_select_o,
  output logic             crystal_gain_select_o,
  output logic             pll_reference_freq_select_o,
  output logic             pll_fast_start_lpm_o,
  output logic             usb2_pll_enable_o,
  output logic             shared_suspend_n_o,
  output logic             crystal_suspend_n_o,
  output logic             afe_suspend_n_o,
  output logic             ss_tx_pll_enable_o,
  output logic             frontend_ready_timer_off_o,
  output logic             global_gating_bypass_o
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 12) $error("upcc_top: ADDR_W must be 2..12");
  end

  // ****************************************
  // status synchronisers and image reload
  // ****************************************
  logic [upcc_pkg::STAT_W-1:0] stat_raw;
  logic [upcc_pkg::STAT_W-1:0] stat;

  assign stat_raw[upcc_pkg::S_CORE]   = core_supply_ok_i;
  assign stat_raw[upcc_pkg::S_POR3V]  = por_3v_ok_i;
  assign stat_raw[upcc_pkg::S_PLL_OK] = pll_usable_i;
  assign stat_raw[upcc_pkg::S_SS_OK]  = ss_tx_pll_usable_i;

  upcc_sync #(
    .W (upcc_pkg::STAT_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (stat_raw),
    .sync_o  (stat)
  );

  upcc_reload_if rl ();

  upcc_reload u_reload (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .image_load_i     (image_load_i),
    .eeprom_present_i (eeprom_present_i),
    .otp_present_i    (otp_present_i),
    .hs_mode_i        (hs_mode_i),
    .eeprom_lpm_hs_i  (eeprom_lpm_hs_i),
    .eeprom_lpm_fs_i  (eeprom_lpm_fs_i),
    .otp_lpm_i        (otp_lpm_i),
    .usb_reset_i      (usb_reset_i),
    .lite_reset_i     (lite_reset_i),
    .rl               (rl.src)
  );

  // ****************************************
  // wishbone slave
  // ****************************************
  logic        req;
  logic        hit;
  logic [31:0] lane_mask;
  logic [31:0] ctl;
  logic [31:0] next_ctl;
  logic [31:0] readback;

  assign req = cyc_i & stb_i & ~ack_o;
  assign hit = adr_i[ADDR_W-1:2] == upcc_pkg::CTL_OFFSET[ADDR_W-1:2];

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[8*b +: 8] = {8{sel_i[b]}};
  end

  // a write answers one cycle later; unmapped words ack with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // reserved positions never store and status bits come from hardware
  always_comb begin
    next_ctl = ctl;
    if (req && we_i && hit) begin
      next_ctl = (ctl & ~(lane_mask & upcc_pkg::CTL_WR_MASK))
               | (dat_i & lane_mask & upcc_pkg::CTL_WR_MASK);
    end
    if (rl.load) begin
      // a hardware reload wins over a software write in the same cycle
      next_ctl[upcc_pkg::B_LPM] = rl.value;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= upcc_pkg::CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  always_comb begin
    readback = ctl & upcc_pkg::CTL_WR_MASK;
    // 3V power-on low forces the core ready indication low
    readback[upcc_pkg::B_CORE_RDY] = stat[upcc_pkg::S_CORE]
                                   & stat[upcc_pkg::S_POR3V];
    readback[upcc_pkg::B_PLL_OK]   = stat[upcc_pkg::S_PLL_OK];
    readback[upcc_pkg::B_SS_OK]    = stat[upcc_pkg::S_SS_OK];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= hit ? readback : 32'h0000_0000;
    end
  end

  // ****************************************
  // common block drive
  // ****************************************
  logic clk_off;
  logic tsel;
  logic next_pll_en;
  logic next_susp_n;
  logic next_xsusp_n;
  logic next_lpm;

  assign clk_off = ctl[upcc_pkg::B_CLK_OFF];
  assign tsel    = ctl[upcc_pkg::B_TEST_SEL];

  // test select hands the pll and suspend controls to the register
  always_comb begin
    next_pll_en  = func_pll_enable_i;
    next_susp_n  = func_shared_suspend_n_i;
    next_xsusp_n = func_crystal_suspend_n_i;
    next_lpm     = func_pll_fast_start_i;
    if (tsel) begin
      next_pll_en  = ctl[upcc_pkg::B_PLL_EN];
      next_susp_n  = ctl[upcc_pkg::B_SUSP_N];
      next_xsusp_n = ctl[upcc_pkg::B_XSUSP_N];
      next_lpm     = ctl[upcc_pkg::B_LPM];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      common_reg_clk_en_o <= 1'b1;
    end else begin
      common_reg_clk_en_o <= ~clk_off;
    end
  end

  // with its register clock gated the common block holds its last inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_block_test_select_o  <= 1'b0;
      crystal_gain_select_o       <= 1'b0;
      pll_reference_freq_select_o <= 1'b0;
      pll_fast_start_lpm_o        <= 1'b0;
      usb2_pll_enable_o           <= 1'b0;
      shared_suspend_n_o          <= 1'b0;
      crystal_suspend_n_o         <= 1'b0;
      ss_tx_pll_enable_o          <= 1'b0;
      frontend_ready_timer_off_o  <= 1'b0;
    end else if (!clk_off) begin
      shared_block_test_select_o  <= tsel;
      crystal_gain_select_o       <= ctl[upcc_pkg::B_XTAL_GAIN];
      pll_reference_freq_select_o <= ctl[upcc_pkg::B_REF_FREQ];
      pll_fast_start_lpm_o        <= next_lpm;
      usb2_pll_enable_o           <= next_pll_en;
      shared_suspend_n_o          <= next_susp_n;
      crystal_suspend_n_o         <= next_xsusp_n;
      ss_tx_pll_enable_o          <= ctl[upcc_pkg::B_SS_EN];
      frontend_ready_timer_off_o  <= ctl[upcc_pkg::B_TIM_OFF];
    end
  end

  // local suspend still works while the common block is gated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      afe_suspend_n_o <= 1'b0;
    end else if (!clk_off) begin
      afe_suspend_n_o <= next_susp_n & local_suspend_n_i;
    end else begin
      afe_suspend_n_o <= shared_suspend_n_o & local_suspend_n_i;
    end
  end

  // chip-wide bypass stays live so a gated block can still be debugged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_gating_bypass_o <= 1'b0;
    end else begin
      global_gating_bypass_o <= ctl[upcc_pkg::B_GATE_BYP];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  clk_gate_a: assert property (
    ack_o && $past(we_i && hit && sel_i[3] && dat_i[upcc_pkg::B_CLK_OFF])
    |=> ##1 !common_reg_clk_en_o
  ) else $error("register clock not gated after disable write");

  test_mux_a: assert property (
    !tsel && !clk_off ##1 !clk_off
    |-> usb2_pll_enable_o == $past(func_pll_enable_i)
  ) else $error("functional pll enable not passed through");

  gain_sel_a: assert property (
    !clk_off ##1 !clk_off
    |-> crystal_gain_select_o == $past(ctl[upcc_pkg::B_XTAL_GAIN])
  ) else $error("crystal gain output does not follow register");

  ref_freq_a: assert property (
    ack_o && $past(we_i && hit && sel_i[2]) && !clk_off
    |=> ##1 pll_reference_freq_select_o == $past(dat_i[upcc_pkg::B_REF_FREQ], 2)
  ) else $error("reference select not applied after write");

  core_ready_a: assert property (
    (!por_3v_ok_i) [*5]
    |=> !readback[upcc_pkg::B_CORE_RDY]
  ) else $error("core ready not forced low without 3v power-on");

  lpm_reload_a: assert property (
    rl.load |=> ctl[upcc_pkg::B_LPM] == $past(rl.value)
  ) else $error("lpm bit not reloaded from image");

  reset_value_a: assert property (
    $past(rst_i) |-> ctl == upcc_pkg::CTL_RESET
  ) else $error("control register reset value wrong");

  afe_override_a: assert property (
    !shared_suspend_n_o && $past(!clk_off) |-> !afe_suspend_n_o
  ) else $error("shared suspend did not override local suspend");

  usable_read_a: assert property (
    ack_o && $past(!we_i && hit)
    |-> dat_o[upcc_pkg::B_PLL_OK] == $past(stat[upcc_pkg::S_PLL_OK])
  ) else $error("pll usable read mismatch");

  reserved_zero_a: assert property (
    ack_o && $past(!we_i) |-> (dat_o & ~upcc_pkg::CTL_WR_MASK
      & ~(32'h0000_0001 << upcc_pkg::B_CORE_RDY)
      & ~(32'h0000_0001 << upcc_pkg::B_PLL_OK)
      & ~(32'h0000_0001 << upcc_pkg::B_SS_OK)) == 32'h0000_0000
  ) else $error("reserved bit read as one");

  freeze_hold_a: assert property (
    clk_off |=> $stable(crystal_gain_select_o) && $stable(usb2_pll_enable_o)
  ) else $error("common block output moved while its clock was gated");

  lpm_drive_a: assert property (
    tsel && !clk_off |=> pll_fast_start_lpm_o == $past(ctl[upcc_pkg::B_LPM])
  ) else $error("fast start output does not follow register");

  pll_enable_a: assert property (
    tsel && !clk_off |=> usb2_pll_enable_o == $past(ctl[upcc_pkg::B_PLL_EN])
  ) else $error("usb2 pll enable does not follow register");

  shared_susp_a: assert property (
    tsel && !clk_off |=> shared_suspend_n_o == $past(ctl[upcc_pkg::B_SUSP_N])
  ) else $error("shared suspend does not follow register");

  xtal_susp_a: assert property (
    tsel && !clk_off |=> crystal_suspend_n_o == $past(ctl[upcc_pkg::B_XSUSP_N])
  ) else $error("crystal suspend does not follow register");

  ss_enable_a: assert property (
    !clk_off |=> ss_tx_pll_enable_o == $past(ctl[upcc_pkg::B_SS_EN])
  ) else $error("transmit pll enable does not follow register");

  ss_usable_a: assert property (
    ack_o && $past(!we_i && hit)
    |-> dat_o[upcc_pkg::B_SS_OK] == $past(stat[upcc_pkg::S_SS_OK])
  ) else $error("transmit pll usable read mismatch");

  timer_off_a: assert property (
    !clk_off |=> frontend_ready_timer_off_o == $past(ctl[upcc_pkg::B_TIM_OFF])
  ) else $error("frontend timer disable does not follow register");

  gate_bypass_a: assert property (
    !$past(rst_i) |-> global_gating_bypass_o == $past(ctl[upcc_pkg::B_GATE_BYP])
  ) else $error("gating bypass does not follow register");

endmodule : upcc_top

// >>> dv/upcc_tb.sv
// self-checking bench for the phy common-block control register.
// assumes upcc_top with ADDR_W=8, a 100 ns clock and a classic wishbone bus.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // signals
  // ****************************************
  logic        clk_i, rst_i, we_i, stb_i, cyc_i, ack_o;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [3:0]  sel_i;
  logic        core_supply_ok_i, por_3v_ok_i, pll_usable_i, ss_tx_pll_usable_i;
  logic        func_pll_enable_i, func_shared_suspend_n_i, func_crystal_suspend_n_i;
  logic        func_pll_fast_start_i, local_suspend_n_i, image_load_i, eeprom_present_i;
  logic        otp_present_i, hs_mode_i, eeprom_lpm_hs_i, eeprom_lpm_fs_i, otp_lpm_i;
  logic        usb_reset_i, lite_reset_i;
  logic        clk_en, tsel, gain, rfreq, lpm_o, pll_en, susp_n, xsusp_n, afe_n;
  logic        ss_en, tim_off, byp;
  logic [11:0] outs;
  int          error_cnt, n_tests;

  assign outs = {clk_en, tsel, gain, rfreq, lpm_o, pll_en, susp_n, xsusp_n, afe_n,
                 ss_en, tim_off, byp};

  upcc_top #(.ADDR_W(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
    .core_supply_ok_i(core_supply_ok_i), .por_3v_ok_i(por_3v_ok_i),
    .pll_usable_i(pll_usable_i), .ss_tx_pll_usable_i(ss_tx_pll_usable_i),
    .func_pll_enable_i(func_pll_enable_i), .func_shared_suspend_n_i(func_shared_suspend_n_i),
    .func_crystal_suspend_n_i(func_crystal_suspend_n_i),
    .func_pll_fast_start_i(func_pll_fast_start_i), .local_suspend_n_i(local_suspend_n_i),
    .image_load_i(image_load_i), .eeprom_present_i(eeprom_present_i),
    .otp_present_i(otp_present_i), .hs_mode_i(hs_mode_i), .eeprom_lpm_hs_i(eeprom_lpm_hs_i),
    .eeprom_lpm_fs_i(eeprom_lpm_fs_i), .otp_lpm_i(otp_lpm_i), .usb_reset_i(usb_reset_i),
    .lite_reset_i(lite_reset_i), .common_reg_clk_en_o(clk_en),
    .shared_block_test_select_o(tsel), .crystal_gain_select_o(gain),
    .pll_reference_freq_select_o(rfreq), .pll_fast_start_lpm_o(lpm_o),
    .usb2_pll_enable_o(pll_en), .shared_suspend_n_o(susp_n), .crystal_suspend_n_o(xsusp_n),
    .afe_suspend_n_o(afe_n), .ss_tx_pll_enable_o(ss_en),
    .frontend_ready_timer_off_o(tim_off), .global_gating_bypass_o(byp)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ****************************************
  // tasks
  // ****************************************
  task summarize;
    $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until ack is seen high, released at the edge that samples it
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    for (int i = 0; i < 20 && ack_o !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    if (ack_o !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no bus acknowledge", $time);
      summarize();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  // one-cycle strobe: 0 image load, 1 usb reset, 2 lite reset; then read bit 17
  task lpm(input int k, input logic e);
    @(posedge clk_i);
    case (k)
      0: image_load_i <= 1'b1;
      1: usb_reset_i <= 1'b1;
      default: lite_reset_i <= 1'b1;
    endcase
    @(posedge clk_i);
    image_load_i <= 1'b0;
    usb_reset_i  <= 1'b0;
    lite_reset_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk({31'h0, rd[17]}, {31'h0, e});
  endtask : lpm

  task settle;
    @(posedge clk_i);
  endtask : settle

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {rst_i, we_i, stb_i, cyc_i, adr_i, dat_i, sel_i} = '0;
    rst_i = 1'b1;
    {core_supply_ok_i, por_3v_ok_i, pll_usable_i, ss_tx_pll_usable_i} = 4'h0;
    {func_pll_enable_i, func_shared_suspend_n_i, func_crystal_suspend_n_i} = 3'b110;
    {func_pll_fast_start_i, local_suspend_n_i, image_load_i, eeprom_present_i} = 4'hC;
    {otp_present_i, hs_mode_i, eeprom_lpm_hs_i, eeprom_lpm_fs_i, otp_lpm_i} = 5'h00;
    {usb_reset_i, lite_reset_i} = 2'b00;
    error_cnt = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) settle();
    chk({20'h0, outs}, {20'h0, 12'h8E8});
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h0001_0000);
    wb(1'b1, 8'h00, 32'h7FFF_FFFF, 4'hF);
    settle();
    chk({20'h0, outs}, {20'h0, 12'hFFF});
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h018B_CA01);
    local_suspend_n_i <= 1'b0;
    repeat (2) settle();
    chk({20'h0, outs}, {20'h0, 12'hFF7});
    local_suspend_n_i <= 1'b1;
    // only the top byte lane is written: clock off, test select cleared
    wb(1'b1, 8'h00, 32'h8000_0000, 4'h8);
    settle();
    chk({20'h0, outs}, {20'h0, 12'h7FF});
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h808B_CA01);
    wb(1'b1, 8'h00, 32'h8000_0000, 4'hF);
    settle();
    chk({20'h0, outs}, {20'h0, 12'h7FE});
    // back to 25 MHz reference and functional signals
    wb(1'b1, 8'h00, 32'h0, 4'hF);
    settle();
    chk({20'h0, outs}, {20'h0, 12'h8E8});
    // functional levels pass through; shared suspend beats an enabled local suspend
    {func_pll_enable_i, func_shared_suspend_n_i, func_crystal_suspend_n_i} <= 3'b001;
    func_pll_fast_start_i <= 1'b0;
    repeat (2) settle();
    chk({20'h0, outs}, {20'h0, 12'h810});
    {func_pll_enable_i, func_shared_suspend_n_i, func_crystal_suspend_n_i} <= 3'b110;
    func_pll_fast_start_i <= 1'b1;
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk(rd, 32'h0);
    {core_supply_ok_i, por_3v_ok_i, pll_usable_i, ss_tx_pll_usable_i} <= 4'hF;
    repeat (8) settle();
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h0004_1400);
    por_3v_ok_i <= 1'b0;
    repeat (8) settle();
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h0000_1400);
    {eeprom_present_i, hs_mode_i, eeprom_lpm_hs_i} <= 3'b111;
    lpm(0, 1'b1);
    wb(1'b1, 8'h00, 32'h0, 4'hF);
    lpm(1, 1'b1);
    hs_mode_i <= 1'b0;
    lpm(0, 1'b0);
    {eeprom_present_i, otp_present_i, otp_lpm_i} <= 3'b011;
    lpm(0, 1'b1);
    wb(1'b1, 8'h00, 32'h0, 4'hF);
    lpm(2, 1'b1);
    otp_present_i <= 1'b0;
    lpm(0, 1'b0);
    wb(1'b1, 8'h00, 32'h0002_0000, 4'hF);
    lpm(1, 1'b0);
    summarize();
  end
endmodule : testbench
